// *** mrsh_handler.sv ***
// How it works
// - A write request is address, code 06, register high/low, value high/low, then CRC low byte first.
// - A valid write stores the value, except to the reset register, and the request bytes are returned unchanged with their CRC.
// - A diagnostic request is address, code 08, two sub-function bytes, two data bytes and CRC.
// - Only sub-function zero is served and the whole received message is echoed back unchanged.
// - A read or write request that cannot be served gets address, function code, one error byte and CRC low first.
// - The function code of an error answer is the requested code plus hex 80.
// - A read or write of an inactive or missing register answers with error code 02.
// - A write outside the register's permitted range answers with error code 03 and changes nothing.
// - Bits of a returned value that carry no information read as zero.
`timescale 1ns/1ps

module mrsh_handler (
	input  wire logic        core_clk_i,     // System clock, 250 MHz
	input  wire logic        srst_i,         // Synchronous reset, active high
	input  wire logic [7:0]  slave_addr_i,   // Own slave address
	input  wire logic        rx_valid_i,     // Received byte strobe
	input  wire logic [7:0]  rx_data_i,      // Received byte
	input  wire logic        rx_eof_i,       // End of frame (line silence) strobe
	output logic             tx_valid_o,     // Answer byte valid
	output logic      [7:0]  tx_data_o,      // Answer byte
	input  wire logic        tx_ready_i,     // Serial side takes the byte
	output logic             busy_o,         // Request being served
	output logic             wr_strobe_o,    // Register written, one cycle
	output logic      [5:0]  wr_reg_o,       // Number of written register
	output logic      [15:0] wr_value_o,     // Value written
	input  wire logic [15:0] pv_i,           // Live process value
	input  wire logic [15:0] peak_i,         // Live peak value
	input  wire logic [15:0] valley_i,       // Live valley value
	input  wire logic [15:0] swver_i         // Software version
);

	mrsh_pkg::mrsh_state_t state_q;
	logic [7:0]  rx_buf_q [0:mrsh_pkg::FRAME_LEN-1];
	logic [7:0]  tx_buf_q [0:mrsh_pkg::FRAME_LEN-1];
	logic [15:0] regs_q   [0:mrsh_pkg::NUM_REGS-1];
	logic [3:0]  rx_cnt_q;
	logic        rx_ovf_q;
	logic [15:0] rx_crc_q;
	logic [15:0] tx_crc_q;
	logic [2:0]  tx_len_q;
	logic [2:0]  tx_idx_q;
	logic [7:0]  tx_data_q;
	logic        frame_ok;
	logic [7:0]  fc;
	logic [15:0] reg_num;
	logic [15:0] value;
	logic [5:0]  ridx;
	logic        reg_exists;
	logic [15:0] rd_value;
	logic [15:0] tx_crc_upd;
	logic        tx_fire;

	// One byte step of the reflected CRC-16
	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++)
		begin
			c = c[0] ? ((c >> 1) ^ mrsh_pkg::CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// Registers that answer a read
	function automatic logic reg_readable(input logic [5:0] r);
		case (r)
			6'h00, 6'h03, 6'h04, 6'h06, 6'h0F, 6'h11, 6'h14, 6'h1B, 6'h23, 6'h24, 6'h25,
			mrsh_pkg::REG_RESET: return 1'b0;
			default: return 1'b1;
		endcase
	endfunction

	// Registers that accept a write
	function automatic logic reg_writable(input logic [5:0] r);
		case (r)
			mrsh_pkg::REG_PV, mrsh_pkg::REG_PEAK, mrsh_pkg::REG_VALLEY, mrsh_pkg::REG_SWVER: return 1'b0;
			mrsh_pkg::REG_RESET: return 1'b1;
			default: return reg_readable(r);
		endcase
	endfunction

	// Permitted range of each writable register, signed counts
	function automatic logic value_in_range(input logic [5:0] r, input logic [15:0] v);
		logic [15:0] lo;
		logic [15:0] hi;
		lo = mrsh_pkg::LIM_0;
		hi = mrsh_pkg::LIM_255;
		case (r)
			6'h01, 6'h02: begin lo = mrsh_pkg::LIM_N1999; hi = mrsh_pkg::LIM_1999; end
			6'h05, 6'h17, 6'h1C, 6'h22: hi = mrsh_pkg::LIM_9999;
			6'h0B, 6'h0E, 6'h1E: hi = mrsh_pkg::LIM_9959;
			6'h12, 6'h13, 6'h15, 6'h16: begin lo = mrsh_pkg::LIM_N1999; hi = mrsh_pkg::LIM_9999; end
			6'h18, 6'h19: hi = mrsh_pkg::LIM_3999;
			6'h1A, 6'h1D: begin lo = mrsh_pkg::LIM_1; hi = mrsh_pkg::LIM_199; end
			6'h21: hi = mrsh_pkg::LIM_233;
			6'h26: begin lo = mrsh_pkg::LIM_32; hi = mrsh_pkg::LIM_126; end
			mrsh_pkg::REG_RESET: return 1'b1;
			default: hi = mrsh_pkg::LIM_255;
		endcase
		return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
	endfunction

	// Request fields, high byte first
	assign fc         = rx_buf_q[1];
	assign reg_num    = {rx_buf_q[2], rx_buf_q[3]};
	assign value      = {rx_buf_q[4], rx_buf_q[5]};
	assign ridx       = reg_num[5:0];
	assign reg_exists = (reg_num <= mrsh_pkg::REG_LAST);
	assign frame_ok   = (rx_cnt_q == mrsh_pkg::REQ_LEN) && !rx_ovf_q &&
	                    (rx_crc_q == mrsh_pkg::CRC_RESIDUE) && (rx_buf_q[0] == slave_addr_i);

	// Read value, live registers from the measuring side
	always_comb
	begin
		case (ridx)
			mrsh_pkg::REG_PV:     rd_value = pv_i;
			mrsh_pkg::REG_PEAK:   rd_value = peak_i;
			mrsh_pkg::REG_VALLEY: rd_value = valley_i;
			mrsh_pkg::REG_SWVER:  rd_value = swver_i;
			default:              rd_value = regs_q[ridx]; // Stored values are range-checked, spare bits zero
		endcase
	end

	// Byte collection and running CRC while idle
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || state_q != mrsh_pkg::ST_RECV || rx_eof_i)
		begin
			rx_cnt_q <= 4'h0;
			rx_ovf_q <= 1'b0;
			rx_crc_q <= mrsh_pkg::CRC_INIT;
		end
		else if (rx_valid_i)
		begin
			rx_crc_q <= crc_byte(rx_crc_q, rx_data_i);
			if (rx_cnt_q == mrsh_pkg::REQ_LEN)
				rx_ovf_q <= 1'b1;
			else
			begin
				rx_buf_q[rx_cnt_q[2:0]] <= rx_data_i;
				rx_cnt_q                <= rx_cnt_q + 4'h1;
			end
		end
	end

	// Sequencing: collect, decide, answer
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			state_q <= mrsh_pkg::ST_RECV;
		else
		begin
			case (state_q)
				mrsh_pkg::ST_RECV: if (rx_eof_i && frame_ok) state_q <= mrsh_pkg::ST_EXEC;
				mrsh_pkg::ST_EXEC: state_q <= (tx_len_q == 3'h0) ? mrsh_pkg::ST_RECV : mrsh_pkg::ST_SEND;
				mrsh_pkg::ST_SEND: if (tx_fire && tx_idx_q == tx_len_q + 3'h1) state_q <= mrsh_pkg::ST_RECV;
				default: state_q <= mrsh_pkg::ST_RECV;
			endcase
		end
	end

	// Decode the request and build the answer body
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			tx_len_q <= 3'h0;
		else if (state_q == mrsh_pkg::ST_RECV && rx_eof_i && frame_ok)
		begin
			for (int i = 0; i < mrsh_pkg::FRAME_LEN; i++)
				tx_buf_q[i] <= rx_buf_q[i];                  // Echo by default
			tx_len_q <= 3'h0;                                // Unknown codes: no answer
			case (fc)
				mrsh_pkg::FC_WRITE_ONE:
				begin
					tx_len_q <= mrsh_pkg::BODY_WRITE;
					if (!reg_exists || !reg_writable(ridx))
					begin
						tx_buf_q[1] <= fc | mrsh_pkg::FC_EXC_FLAG;
						tx_buf_q[2] <= mrsh_pkg::EXC_BAD_REG;
						tx_len_q    <= mrsh_pkg::BODY_EXC;
					end
					else if (!value_in_range(ridx, value))
					begin
						tx_buf_q[1] <= fc | mrsh_pkg::FC_EXC_FLAG;
						tx_buf_q[2] <= mrsh_pkg::EXC_BAD_VALUE;
						tx_len_q    <= mrsh_pkg::BODY_EXC;
					end
				end
				mrsh_pkg::FC_DIAG:
					if (reg_num == mrsh_pkg::DIAG_SUB_ECHO)
						tx_len_q <= mrsh_pkg::BODY_WRITE;
				mrsh_pkg::FC_READ_HOLD, mrsh_pkg::FC_READ_INPUT:
				begin
					if (!reg_exists || !reg_readable(ridx) || value != mrsh_pkg::READ_COUNT_ONE)
					begin
						tx_buf_q[1] <= fc | mrsh_pkg::FC_EXC_FLAG;
						tx_buf_q[2] <= mrsh_pkg::EXC_BAD_REG;
						tx_len_q    <= mrsh_pkg::BODY_EXC;
					end
					else
					begin
						tx_buf_q[2] <= mrsh_pkg::READ_BYTES;
						tx_buf_q[3] <= rd_value[15:8];
						tx_buf_q[4] <= rd_value[7:0];
						tx_len_q    <= mrsh_pkg::BODY_READ;
					end
				end
				default: tx_len_q <= 3'h0;
			endcase
		end
	end

	// Register store; out-of-range values leave it untouched
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			for (int i = 0; i < mrsh_pkg::NUM_REGS; i++)
				regs_q[i] <= mrsh_pkg::REG_RST_VAL;
			regs_q[mrsh_pkg::REG_CYCLE1] <= mrsh_pkg::CYCLE_RST_VAL;
			regs_q[mrsh_pkg::REG_CYCLE2] <= mrsh_pkg::CYCLE_RST_VAL;
			wr_strobe_o <= 1'b0;
			wr_reg_o    <= 6'h00;
			wr_value_o  <= 16'h0000;
		end
		else
		begin
			wr_strobe_o <= 1'b0;
			if (state_q == mrsh_pkg::ST_RECV && rx_eof_i && frame_ok && fc == mrsh_pkg::FC_WRITE_ONE &&
			    reg_exists && reg_writable(ridx) && value_in_range(ridx, value))
			begin
				if (ridx != mrsh_pkg::REG_RESET)
					regs_q[ridx] <= value;
				wr_strobe_o <= 1'b1;
				wr_reg_o    <= ridx;
				wr_value_o  <= value;
			end
		end
	end

	// Answer bytes: body, then CRC low byte and high byte
	assign tx_valid_o = (state_q == mrsh_pkg::ST_SEND);
	assign tx_data_o  = tx_data_q;
	assign tx_fire    = tx_valid_o && tx_ready_i;
	assign tx_crc_upd = crc_byte(tx_crc_q, tx_data_q);
	assign busy_o     = (state_q != mrsh_pkg::ST_RECV);

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			tx_idx_q  <= 3'h0;
			tx_data_q <= 8'h00;
			tx_crc_q  <= mrsh_pkg::CRC_INIT;
		end
		else if (state_q == mrsh_pkg::ST_EXEC)
		begin
			tx_idx_q  <= 3'h0;
			tx_data_q <= tx_buf_q[0];
			tx_crc_q  <= mrsh_pkg::CRC_INIT;
		end
		else if (tx_fire)
		begin
			tx_idx_q <= tx_idx_q + 3'h1;
			if (tx_idx_q < tx_len_q)
			begin
				tx_crc_q <= tx_crc_upd;
				if (tx_idx_q + 3'h1 == tx_len_q)
					tx_data_q <= tx_crc_upd[7:0];
				else
					tx_data_q <= tx_buf_q[tx_idx_q + 3'h1];
			end
			else if (tx_idx_q == tx_len_q)
				tx_data_q <= tx_crc_q[15:8];
		end
	end

endmodule

// *** mrsh_pkg.sv ***
// Shared constants of the Modbus RTU slave handler
package mrsh_pkg;

	// Function codes and exception handling
	localparam logic [7:0]  FC_READ_HOLD   = 8'h03;
	localparam logic [7:0]  FC_READ_INPUT  = 8'h04;
	localparam logic [7:0]  FC_WRITE_ONE   = 8'h06;
	localparam logic [7:0]  FC_DIAG        = 8'h08;
	localparam logic [7:0]  FC_EXC_FLAG    = 8'h80;
	localparam logic [7:0]  EXC_BAD_REG    = 8'h02;
	localparam logic [7:0]  EXC_BAD_VALUE  = 8'h03;
	localparam logic [15:0] DIAG_SUB_ECHO  = 16'h0000;
	localparam logic [15:0] READ_COUNT_ONE = 16'h0001;
	localparam logic [7:0]  READ_BYTES     = 8'h02;

	// CRC-16 of the RTU framing
	localparam logic [15:0] CRC_INIT   = 16'hFFFF;
	localparam logic [15:0] CRC_POLY   = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;

	// Frame geometry: every accepted request is eight bytes
	localparam int          FRAME_LEN  = 8;
	localparam logic [3:0]  REQ_LEN    = 4'h8;
	localparam logic [2:0]  BODY_WRITE = 3'h6;
	localparam logic [2:0]  BODY_READ  = 3'h5;
	localparam logic [2:0]  BODY_EXC   = 3'h3;

	// Register numbering
	localparam int          NUM_REGS   = 44;
	localparam logic [15:0] REG_LAST   = 16'h002B;
	localparam logic [5:0]  REG_PV     = 6'h27;
	localparam logic [5:0]  REG_PEAK   = 6'h28;
	localparam logic [5:0]  REG_VALLEY = 6'h29;
	localparam logic [5:0]  REG_SWVER  = 6'h2A;
	localparam logic [5:0]  REG_RESET  = 6'h2B;
	localparam logic [5:0]  REG_CYCLE1 = 6'h1A;
	localparam logic [5:0]  REG_CYCLE2 = 6'h1D;
	localparam logic [15:0] REG_RST_VAL   = 16'h0000;
	localparam logic [15:0] CYCLE_RST_VAL = 16'h0001;

	// Permitted value limits, signed 16-bit counts
	localparam logic [15:0] LIM_N1999 = 16'hF831;
	localparam logic [15:0] LIM_0     = 16'h0000;
	localparam logic [15:0] LIM_1     = 16'h0001;
	localparam logic [15:0] LIM_32    = 16'h0020;
	localparam logic [15:0] LIM_126   = 16'h007E;
	localparam logic [15:0] LIM_199   = 16'h00C7;
	localparam logic [15:0] LIM_233   = 16'h00E9;
	localparam logic [15:0] LIM_255   = 16'h00FF;
	localparam logic [15:0] LIM_1999  = 16'h07CF;
	localparam logic [15:0] LIM_3999  = 16'h0F9F;
	localparam logic [15:0] LIM_9959  = 16'h26E7;
	localparam logic [15:0] LIM_9999  = 16'h270F;

	// Handler states, one-hot
	typedef enum logic [2:0] {
		ST_RECV = 3'b001,
		ST_EXEC = 3'b010,
		ST_SEND = 3'b100
	} mrsh_state_t;

endpackage

// *** mrsh_handler_chk.sv ***
`timescale 1ns/1ps
module mrsh_handler_chk (
	input wire logic        core_clk_i,   // System clock
	input wire logic        srst_i,       // Synchronous reset
	input wire logic [7:0]  slave_addr_i, // Own address
	input wire logic        rx_eof_i,     // End of frame
	input wire logic        tx_valid_o,   // Answer byte valid
	input wire logic [7:0]  tx_data_o,    // Answer byte
	input wire logic        tx_ready_i,   // Answer byte taken
	input wire logic        busy_o,       // Request in service
	input wire logic        wr_strobe_o,  // Write pulse
	input wire logic [5:0]  wr_reg_o,     // Written register
	input wire logic [15:0] wr_value_o    // Written value
);
	// All checks share the one clock and reset
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	wr_pulse_a: assert property (wr_strobe_o |=> !wr_strobe_o)
		else $error("Write strobe longer than one cycle");
	wr_echo_a: assert property (wr_strobe_o |=> tx_valid_o && tx_data_o == slave_addr_i)
		else $error("Write echo does not open with own address");
	wr_busy_a: assert property (wr_strobe_o |-> busy_o)
		else $error("Write strobe outside a served request");
	answer_start_a: assert property ($rose(busy_o) |-> !tx_valid_o ##1 (tx_valid_o == busy_o))
		else $error("Answer late after frame end");
	busy_cause_a: assert property ($rose(busy_o) |-> $past(rx_eof_i))
		else $error("Service started without frame end");
	idle_quiet_a: assert property (!busy_o |-> !tx_valid_o)
		else $error("Answer byte while idle");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("Answer byte changed while stalled");
	busy_end_a: assert property ($fell(busy_o) |-> $past(tx_valid_o && tx_ready_i) || !$past(tx_valid_o))
		else $error("Service ended without a taken byte");
	wr_hold_a: assert property (!wr_strobe_o |-> $stable(wr_value_o) && $stable(wr_reg_o))
		else $error("Write outputs moved without strobe");
endmodule

bind mrsh_handler mrsh_handler_chk i_mrsh_handler_chk (.core_clk_i, .srst_i, .slave_addr_i,
	.rx_eof_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .busy_o, .wr_strobe_o, .wr_reg_o, .wr_value_o);

// *** mrsh_master_model.sv ***
`timescale 1ns/1ps
module mrsh_master_model (
	input  wire logic       core_clk_i, // System clock
	output logic            rx_valid_o, // Byte strobe to handler
	output logic      [7:0] rx_data_o,  // Byte to handler
	output logic            rx_eof_o,   // Line silence strobe
	input  wire logic       tx_valid_i, // Answer byte offered
	input  wire logic [7:0] tx_data_i,  // Answer byte
	output logic            tx_ready_o  // Answer byte taken
);
	// Quiet line at time zero
	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		rx_eof_o = 1'b0;
		tx_ready_o = 1'b0;
	end

	// Sends a frame back to back, then gathers up to n answer bytes, or every byte offered in 40 cycles when n is 0
	task automatic xfer(input logic [7:0] f[$], input int n, input bit slow, output logic [7:0] a[$]);
		int c;
		a = {};
		c = 0;
		foreach (f[i])
		begin
			@(negedge core_clk_i);
			rx_valid_o = 1'b1;
			rx_data_o = f[i];
		end
		@(negedge core_clk_i);
		rx_valid_o = 1'b0;
		rx_data_o = ~rx_data_o; // Released line shows no stale byte
		rx_eof_o = 1'b1;
		@(negedge core_clk_i);
		rx_eof_o = 1'b0;
		while (c < (n > 0 ? 200 : 40) && !(n > 0 && a.size() == n))
		begin
			@(negedge core_clk_i);
			c++;
			tx_ready_o = !slow || c[1]; // Stalls half the time when slow
			if (tx_valid_i && tx_ready_o)
				a.push_back(tx_data_i);
		end
		@(negedge core_clk_i);
		tx_ready_o = 1'b0;
	endtask
endmodule

// *** mrsh_handler_test.sv ***
`timescale 1ns/1ps
module mrsh_handler_test;
	logic        core_clk_i;
	logic        srst_i;
	logic [7:0]  slave_addr_i;
	logic        rx_valid_i;
	logic [7:0]  rx_data_i;
	logic        rx_eof_i;
	logic        tx_valid_o;
	logic [7:0]  tx_data_o;
	logic        tx_ready_i;
	logic        busy_o;
	logic        wr_strobe_o;
	logic [5:0]  wr_reg_o;
	logic [15:0] wr_value_o;
	logic [15:0] pv_i;
	int          failures;
	int          tests_run;
	int          wr_cnt;

	mrsh_handler i_mrsh_handler (.core_clk_i, .srst_i, .slave_addr_i, .rx_valid_i, .rx_data_i, .rx_eof_i,
		.tx_valid_o, .tx_data_o, .tx_ready_i, .busy_o, .wr_strobe_o, .wr_reg_o, .wr_value_o, .pv_i,
		.peak_i(~pv_i), .valley_i(pv_i ^ 16'h00FF), .swver_i({pv_i[7:0], pv_i[15:8]}));
	mrsh_master_model i_mrsh_master_model (.core_clk_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
		.rx_eof_o(rx_eof_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));

	// Clock and write pulse counter
	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) if (wr_strobe_o === 1'b1) wr_cnt++;

	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	// Appends CRC-16, low byte first
	function automatic void seal(ref logic [7:0] f[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (f[i])
		begin
			c ^= {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
	endfunction

	// One request; m[0] stalls answer, m[1] spoils CRC; ne leading bytes of e expected before CRC
	task automatic run(input logic [47:0] h, input logic [7:0] adr, input int m, input logic [47:0] e, input int ne);
		logic [7:0] f[$];
		logic [7:0] x[$];
		logic [7:0] a[$];
		int w;
		for (int i = 0; i < 6; i++) f.push_back(h[47 - 8 * i -: 8]);
		for (int i = 0; i < ne; i++) x.push_back(e[47 - 8 * i -: 8]);
		seal(f);
		if (ne > 0) seal(x);
		if (m[1]) f[7] = ~f[7];
		w = wr_cnt;
		@(negedge core_clk_i);
		slave_addr_i = adr;
		i_mrsh_master_model.xfer(f, x.size(), m[0], a);
		check("answer length", 16'(a.size()), 16'(x.size()));
		foreach (x[i]) check("answer byte", {8'h00, a[i]}, {8'h00, x[i]});
		check("write count", 16'(wr_cnt - w), 16'(ne == 6 && h[39:32] == 8'h06));
		check("idle after answer", {15'h0000, busy_o}, 16'h0000);
	endtask

	task automatic t_write;
		run(48'h1406_0012_012C, 8'h14, 1, 48'h1406_0012_012C, 6);
		check("written register", {10'h000, wr_reg_o}, 16'h0012);
		check("written value", wr_value_o, 16'h012C);
		run(48'h1406_0015_FC18, 8'h14, 0, 48'h1406_0015_FC18, 6);
		check("signed value", wr_value_o, 16'hFC18);
	endtask

	task automatic t_read;
		run(48'h1403_0012_0001, 8'h14, 0, 48'h1403_0201_2C00, 5);
		run(48'h1404_0027_0001, 8'h14, 1, 48'h1404_020A_BC00, 5);
		run(48'h1403_001A_0001, 8'h14, 0, 48'h1403_0200_0100, 5);
	endtask

	task automatic t_diag;
		run(48'h1408_0000_1234, 8'h14, 1, 48'h1408_0000_1234, 6);
		run(48'h0108_2233_0000, 8'h01, 0, 48'h0000_0000_0000, 0);
	endtask

	task automatic t_exc;
		logic [47:0] req [4] = '{48'h0503_0004_0001, 48'h7806_0023_0000, 48'h0106_000C_012C, 48'h1403_0012_0002};
		logic [23:0] ans [4] = '{24'h0583_02, 24'h7886_02, 24'h0186_03, 24'h1483_02};
		for (int i = 0; i < 4; i++)
			run(req[i], req[i][47:40], i % 2, {ans[i], 24'h00_0000}, 3);
		check("value after refusal", wr_value_o, 16'hFC18);
		run(48'h0103_000C_0001, 8'h01, 0, 48'h0103_0200_0000, 5);
	endtask

	task automatic t_drop;
		run(48'h1406_0012_0055, 8'h15, 0, 48'h0000_0000_0000, 0);
		run(48'h1406_0012_0055, 8'h14, 2, 48'h0000_0000_0000, 0);
		run(48'h1403_0012_0001, 8'h14, 0, 48'h1403_0201_2C00, 5);
		run(48'h1410_0012_0001, 8'h14, 0, 48'h0000_0000_0000, 0);
	endtask

	// Live registers, write-only reset register, lower range edge, numbers past the end
	task automatic t_live;
		run(48'h1404_0028_0001, 8'h14, 0, 48'h1404_02F5_4300, 5);
		run(48'h1403_0029_0001, 8'h14, 1, 48'h1403_020A_4300, 5);
		run(48'h1403_002A_0001, 8'h14, 0, 48'h1403_02BC_0A00, 5);
		run(48'h1406_0027_0001, 8'h14, 0, 48'h1486_0200_0000, 3);
		run(48'h1406_002B_0001, 8'h14, 0, 48'h1406_002B_0001, 6);
		check("reset register", {10'h000, wr_reg_o}, 16'h002B);
		run(48'h1403_002B_0001, 8'h14, 0, 48'h1483_0200_0000, 3);
		run(48'h1403_002C_0001, 8'h14, 1, 48'h1483_0200_0000, 3);
		run(48'h1406_0026_001F, 8'h14, 1, 48'h1486_0300_0000, 3);
		run(48'h1406_0026_0020, 8'h14, 0, 48'h1406_0026_0020, 6);
		check("lowest value", wr_value_o, 16'h0020);
	endtask

	// Reset in mid-run returns the store and write outputs to their reset values
	task automatic t_reset;
		@(negedge core_clk_i);
		srst_i = 1'b1;
		repeat (2) @(negedge core_clk_i);
		srst_i = 1'b0;
		check("value after reset", wr_value_o, 16'h0000);
		check("register after reset", {10'h000, wr_reg_o}, 16'h0000);
		run(48'h1403_0012_0001, 8'h14, 0, 48'h1403_0200_0000, 5);
		run(48'h1403_001A_0001, 8'h14, 1, 48'h1403_0200_0100, 5);
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		failures = 0;
		tests_run = 0;
		wr_cnt = 0;
		srst_i = 1'b1;
		slave_addr_i = 8'h00;
		pv_i = 16'h0ABC;
		repeat (16) @(negedge core_clk_i);
		srst_i = 1'b0;
		t_write();
		t_read();
		t_diag();
		t_exc();
		t_live();
		t_drop();
		t_reset();
		end_sim();
	end

	// Watchdog, well beyond the expected run
	initial
	begin
		#100000;
		failures++;
		end_sim();
	end
endmodule
